// >>> jet_dispense_command_parser.sv
/*
  ASCII command interpreter for a jet dispensing controller: parses
  commands, drives actuators, counts drops, builds query replies.
  Assumes a UART outside delivers received bytes and drains reply bytes
  on mclk, and that analog readings arrive already on mclk.
*/
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "jdc_map.svh"
module jet_dispense_command_parser #(
  parameter int unsigned DROP_GAP   = `DROP_GAP_CYC,
  parameter int unsigned MINUTE     = `MINUTE_CYC,
  // Arbitrary identification value
  parameter logic [63:0] VERSION_ID = 64'h4a44_435f_3030_3031
) (
  input  wire logic           mclk,
  input  wire logic           rst,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic           rxValid,
  input  wire logic [7:0]     rxByte,
  output logic                txValid,
  output logic      [7:0]     txByte,
  input  wire logic           txReady,
  input  wire jdc_pkg::sense_t sense,
  output jdc_pkg::act_t       act
);
  logic        ctrlEn;
  logic [1:0]  swRaw;
  logic [1:0]  swStable;
  jdc_pkg::parse_t pState;
  jdc_pkg::reply_t rState;
  jdc_pkg::cmd_t   cmd;
  logic [15:0] vals [3];
  logic [15:0] acc;
  logic        haveDig;
  logic        exec;
  logic        cmdErr;
  logic        isQuery;
  logic        apply;
  logic        valveOpen, vacuumOn, probeRetract, jetHeaterOn, melterHeaterOn;
  logic [2:0]  recipe;
  logic [15:0] psiSet, jetTempSet, melterTempSet, idleMins;
  logic [15:0] recipeDrops [6];
  logic        errFlag;
  logic        busy;
  logic        fire;
  logic [15:0] dropsLeft;
  logic [31:0] gapCnt;
  logic [31:0] dropCount;
  logic [31:0] idleCyc;
  logic [15:0] idleMinCnt;
  logic        idleOff;
  logic [7:0]  rbuf [16];
  logic [3:0]  rLen;
  logic [31:0] numVal;
  logic [31:0] qVal;
  logic        qTenths;
  logic        tenths, dotDone, firstDig, clrReply, clrDone;
  logic [7:0]  txByteR;
  logic [7:0]  lowDigit;
  logic [31:0] rdMux;
  logic        mapped;

  wire isDigit  = rxByte >= `CH_ZERO && rxByte <= `CH_NINE;
  wire isLetter = rxByte >= `CH_A && rxByte <= `CH_Z;
  wire isSemi   = rxByte == `CH_SEMI;
  wire isSep    = rxByte == `CH_COMMA || rxByte == `CH_SPACE;
  wire isBlank  = rxByte == `CH_SPACE || rxByte == `CH_CR || rxByte == `CH_LF;
  wire rxTake   = rxValid && ctrlEn;

  // Pins pass three flops; a change is taken once stages two and three agree
  assign swRaw = {sense.tactileSw, sense.heightSw};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sw
      logic [2:0] sh;
      logic       st;
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          sh <= 3'h0;
          st <= 1'b0;
        end else begin
          sh <= {sh[1:0], swRaw[g]};
          if (sh[1] == sh[2]) begin
            st <= sh[2];
          end
        end
      end
      assign swStable[g] = st;
    end
  endgenerate

  // Byte parser; nothing is acted on until the terminating semicolon
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pState  <= jdc_pkg::P_C0;
      cmd     <= '0;
      acc     <= 16'h0000;
      haveDig <= 1'b0;
      exec    <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        vals[i] <= 16'h0000;
      end
    end else begin
      exec <= 1'b0;
      if (rxTake) begin
        case (pState)
          jdc_pkg::P_C0: begin
            if (!isBlank && !isSemi) begin
              cmd.code  <= isLetter ? {rxByte, 8'h00} : 16'h0000;
              cmd.bad   <= !isLetter;
              cmd.nVals <= 2'h0;
              acc       <= 16'h0000;
              haveDig   <= 1'b0;
              pState    <= isLetter ? jdc_pkg::P_C1 : jdc_pkg::P_ARGS;
            end
          end
          jdc_pkg::P_C1: begin
            cmd.code[7:0] <= rxByte;
            cmd.bad       <= cmd.bad | !isLetter;
            if (isSemi) begin
              exec   <= 1'b1;
              pState <= jdc_pkg::P_C0;
            end else begin
              pState <= jdc_pkg::P_ARGS;
            end
          end
          jdc_pkg::P_ARGS: begin
            if (isDigit) begin
              // Oversized values are refused rather than wrapped
              if (acc > `ACC_MAX) begin
                cmd.bad <= 1'b1;
              end
              acc     <= 16'(acc * 16'h000a + {8'h00, rxByte - `CH_ZERO});
              haveDig <= 1'b1;
            end else if (isSep || isSemi) begin
              if (haveDig) begin
                if (cmd.nVals == 2'h3) begin
                  cmd.bad <= 1'b1;
                end else begin
                  vals[cmd.nVals] <= acc;
                  cmd.nVals       <= cmd.nVals + 2'h1;
                end
              end
              acc     <= 16'h0000;
              haveDig <= 1'b0;
              if (isSemi) begin
                exec   <= 1'b1;
                pState <= jdc_pkg::P_C0;
              end
            end else begin
              cmd.bad <= 1'b1;
            end
          end
          default: pState <= jdc_pkg::P_C0;
        endcase
      end
    end
  end

  // Command check: any fault leaves every setting untouched
  always_comb begin
    cmdErr  = cmd.bad;
    isQuery = 1'b0;
    case (cmd.code)
      `RECIPE_PICK_CMD:      cmdErr |= cmd.nVals != 2'h1 || vals[0] > `MAX_RECIPE;
      `DISPENSE_GO_CMD:      cmdErr |= cmd.nVals != 2'h0 || busy;
      `VALVE_CMD:            cmdErr |= cmd.nVals != 2'h2 || vals[0] != 16'h0000
                                       || vals[1] > 16'h0001;
      `DROP_COUNT_CLEAR_CMD: cmdErr |= cmd.nVals > 2'h1;
      `FLUID_PSI_SET_CMD:    cmdErr |= cmd.nVals != 2'h1 || vals[0] >= `PSI_LIMIT;
      `VACUUM_CMD,
      `HEIGHT_PROBE_CMD:     cmdErr |= cmd.nVals != 2'h1 || vals[0] > 16'h0001;
      `TEMP_SET_CMD:         cmdErr |= cmd.nVals != 2'h2 || vals[0] < 16'h0001
                                       || vals[0] > 16'h0002 || vals[1] >= `TEMP_LIMIT;
      `HEATER_SWITCH_CMD:    cmdErr |= cmd.nVals != 2'h2 || vals[0] < 16'h0001
                                       || vals[0] > 16'h0002 || vals[1] > 16'h0001;
      `HEATER_IDLE_OFF_CMD:  cmdErr |= cmd.nVals != 2'h1;
      `TRIGGER_DROP_COUNT_CMD: cmdErr |= cmd.nVals != 2'h3 || vals[0] > `MAX_RECIPE
                                         || vals[1] > 16'h0001;
      `VERSION_QUERY, `DROP_COUNT_QUERY, `ERROR_QUERY, `VALVE_STATE_QUERY,
      `HEIGHT_SWITCH_QUERY, `TACTILE_SWITCH_QUERY: begin
        isQuery = 1'b1;
        cmdErr |= cmd.nVals != 2'h0;
      end
      `FLUID_PSI_QUERY: begin
        isQuery = 1'b1;
        cmdErr |= cmd.nVals > 2'h1;
      end
      `TEMP_QUERY: begin
        isQuery = 1'b1;
        cmdErr |= cmd.nVals != 2'h1 || vals[0] < 16'h0001 || vals[0] > 16'h0002;
      end
      default: cmdErr = 1'b1;
    endcase
  end

  assign apply = exec && !cmdErr;

  // Settings; a command arriving with the idle timeout wins over it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      valveOpen      <= 1'b0;
      vacuumOn       <= 1'b0;
      probeRetract   <= 1'b0;
      jetHeaterOn    <= 1'b0;
      melterHeaterOn <= 1'b0;
      recipe         <= 3'h0;
      psiSet         <= 16'h0000;
      jetTempSet     <= 16'h0000;
      melterTempSet  <= 16'h0000;
      idleMins       <= 16'h0000;
      for (int i = 0; i < 6; i++) begin
        recipeDrops[i] <= 16'h0000;
      end
    end else begin
      if (idleOff) begin
        jetHeaterOn    <= 1'b0;
        melterHeaterOn <= 1'b0;
      end
      if (apply) begin
        case (cmd.code)
          `RECIPE_PICK_CMD:    recipe <= vals[0][2:0];
          `VALVE_CMD:          valveOpen <= vals[1][0];
          `FLUID_PSI_SET_CMD:  psiSet <= vals[0];
          `VACUUM_CMD:         vacuumOn <= vals[0][0];
          `HEIGHT_PROBE_CMD:   probeRetract <= vals[0][0];
          `TEMP_SET_CMD: begin
            if (vals[0][1]) begin
              melterTempSet <= vals[1];
            end else begin
              jetTempSet <= vals[1];
            end
          end
          `HEATER_SWITCH_CMD: begin
            if (vals[0][1]) begin
              melterHeaterOn <= vals[1][0];
            end else begin
              jetHeaterOn <= vals[1][0];
            end
          end
          `HEATER_IDLE_OFF_CMD: idleMins <= vals[0];
          `TRIGGER_DROP_COUNT_CMD: recipeDrops[vals[0][2:0]] <= vals[2];
          default: ;
        endcase
      end
    end
  end

  // Stored error: a new fault wins over the clear from a status reply
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      errFlag <= 1'b0;
    end else if (exec && cmdErr) begin
      errFlag <= 1'b1;
    end else if (clrDone) begin
      errFlag <= 1'b0;
    end
  end

  // Drop engine: one fire pulse per drop, spaced by DROP_GAP cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy      <= 1'b0;
      fire      <= 1'b0;
      dropsLeft <= 16'h0000;
      gapCnt    <= 32'h0;
    end else begin
      fire <= 1'b0;
      if (!busy) begin
        if (apply && cmd.code == `DISPENSE_GO_CMD && recipeDrops[recipe] != 16'h0000) begin
          busy      <= 1'b1;
          dropsLeft <= recipeDrops[recipe];
          gapCnt    <= 32'h0;
        end
      end else if (gapCnt == 32'h0) begin
        fire      <= 1'b1;
        gapCnt    <= 32'(DROP_GAP - 1);
        dropsLeft <= dropsLeft - 16'h0001;
        if (dropsLeft == 16'h0001) begin
          busy <= 1'b0;
        end
      end else begin
        gapCnt <= gapCnt - 32'h1;
      end
    end
  end

  // Drop counter; a drop landing with the clear is still counted
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dropCount <= 32'h0;
    end else if (apply && cmd.code == `DROP_COUNT_CLEAR_CMD) begin
      dropCount <= fire ? 32'h1 : 32'h0;
    end else if (fire) begin
      dropCount <= dropCount + 32'h1;
    end
  end

  // Idle timer in whole minutes; firing or a heater command restarts it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idleCyc    <= 32'h0;
      idleMinCnt <= 16'h0000;
    end else if (busy || (apply && cmd.code == `HEATER_SWITCH_CMD)) begin
      idleCyc    <= 32'h0;
      idleMinCnt <= 16'h0000;
    end else if (idleCyc == 32'(MINUTE - 1)) begin
      idleCyc <= 32'h0;
      if (idleMinCnt != 16'hffff) begin
        idleMinCnt <= idleMinCnt + 16'h0001;
      end
    end else begin
      idleCyc <= idleCyc + 32'h1;
    end
  end

  assign idleOff = idleMins != 16'h0000 && idleMinCnt >= idleMins
                   && (jetHeaterOn || melterHeaterOn);

  always_comb begin
    qTenths = 1'b0;
    case (cmd.code)
      `DROP_COUNT_QUERY:     qVal = dropCount;
      `ERROR_QUERY:          qVal = {31'h0, errFlag};
      `VALVE_STATE_QUERY:    qVal = {31'h0, !valveOpen};
      `HEIGHT_SWITCH_QUERY:  qVal = {31'h0, swStable[0]};
      `TACTILE_SWITCH_QUERY: qVal = {31'h0, swStable[1]};
      `FLUID_PSI_QUERY: begin
        qVal    = {16'h0000, sense.psiTenths};
        qTenths = 1'b1;
      end
      `TEMP_QUERY: begin
        qVal    = {16'h0000, vals[0][1] ? sense.melterTempTenths : sense.jetTempTenths};
        qTenths = 1'b1;
      end
      default: qVal = 32'h0;
    endcase
  end

  assign lowDigit = 8'(numVal % 32'h0000000a);

  // Reply builder: text is stored last byte first, then sent from the top
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rState   <= jdc_pkg::R_IDLE;
      rLen     <= 4'h0;
      numVal   <= 32'h0;
      tenths   <= 1'b0;
      dotDone  <= 1'b0;
      firstDig <= 1'b0;
      clrReply <= 1'b0;
      clrDone  <= 1'b0;
      txByteR  <= 8'h00;
      for (int i = 0; i < 16; i++) begin
        rbuf[i] <= 8'h00;
      end
    end else begin
      clrDone <= 1'b0;
      case (rState)
        jdc_pkg::R_IDLE: begin
          // Queries during a drop series get no reply
          if (apply && isQuery && !busy) begin
            rbuf[0]  <= `CH_SEMI;
            rLen     <= 4'h1;
            dotDone  <= 1'b0;
            firstDig <= 1'b0;
            numVal   <= qVal;
            tenths   <= qTenths;
            clrReply <= cmd.code == `VALVE_STATE_QUERY;
            if (cmd.code == `VERSION_QUERY) begin
              for (int i = 0; i < 8; i++) begin
                rbuf[i + 1] <= VERSION_ID[8 * i +: 8];
              end
              rLen    <= 4'h9;
              txByteR <= VERSION_ID[63:56];
              rState  <= jdc_pkg::R_SEND;
            end else begin
              rState <= jdc_pkg::R_CONV;
            end
          end
        end
        jdc_pkg::R_CONV: begin
          if (tenths && firstDig && !dotDone) begin
            rbuf[rLen] <= `CH_DOT;
            rLen       <= rLen + 4'h1;
            dotDone    <= 1'b1;
          end else begin
            rbuf[rLen] <= `CH_ZERO + lowDigit;
            rLen       <= rLen + 4'h1;
            numVal     <= numVal / 32'h0000000a;
            firstDig   <= 1'b1;
            if (numVal < 32'h0000000a && (!tenths || firstDig)) begin
              txByteR <= `CH_ZERO + lowDigit;
              rState  <= jdc_pkg::R_SEND;
            end
          end
        end
        jdc_pkg::R_SEND: begin
          if (txReady) begin
            rLen <= rLen - 4'h1;
            if (rLen == 4'h1) begin
              rState <= jdc_pkg::R_IDLE;
              clrDone <= clrReply;
            end else begin
              txByteR <= rbuf[rLen - 4'h2];
            end
          end
        end
        default: rState <= jdc_pkg::R_IDLE;
      endcase
    end
  end

  assign txValid = rState == jdc_pkg::R_SEND;
  assign txByte  = txByteR;

  // APB slave: zero wait states, read data captured in the setup phase
  always_comb begin
    mapped = 1'b1;
    rdMux  = 32'h0;
    case (paddr)
      `CTRL_OFS:   rdMux = {31'h0, ctrlEn};
      `STATUS_OFS: begin
        rdMux[`ST_VALVE]            = valveOpen;
        rdMux[`ST_JHEAT]            = jetHeaterOn;
        rdMux[`ST_MHEAT]            = melterHeaterOn;
        rdMux[`ST_VAC]              = vacuumOn;
        rdMux[`ST_PROBE]            = probeRetract;
        rdMux[`ST_ERR]              = errFlag;
        rdMux[`ST_BUSY]             = busy;
        rdMux[`ST_RECIPE +: 3]      = recipe;
        rdMux[`ST_PSI +: 16]        = psiSet;
      end
      `DROPS_OFS:  rdMux = dropCount;
      `SETPT_OFS:  rdMux = {melterTempSet, jetTempSet};
      default:     mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrlEn <= `CTRL_RST;
      prdata <= 32'h0;
    end else begin
      if (psel && !penable) begin
        prdata <= rdMux;
      end
      if (psel && penable && pwrite && paddr == `CTRL_OFS) begin
        ctrlEn <= pwdata[0];
      end
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign act = '{valveOpen, fire, vacuumOn, probeRetract, jetHeaterOn, melterHeaterOn,
                 recipe, psiSet, jetTempSet, melterTempSet};
endmodule // jet_dispense_command_parser

// >>> jdc_map.svh
/*
  Constants for the jet dispense command parser: register offsets, field
  positions, reset values, ASCII codes, command codes and timing counts.
  Assumes a 25 MHz system clock and byte-wide ASCII traffic.
*/
`ifndef JDC_MAP_SVH
`define JDC_MAP_SVH
// Contract
// - Command is two letters plus comma-separated values; acted on only at semicolon.
// - Recipe pick carries one identifier 0 to 5; it becomes current.
// - Dispense go fires the jet with the selected recipe's drop count.
// - Selected recipe persists across repeated dispense go commands.
// - Each recipe holds a drop count per dispense trigger.
// - Valve command: identifier must be 0; state 1 opens, 0 closes.
// - Counter clear sets the drop counter to zero.
// - Fluid pressure set stores psi set point; host keeps it below 75.
// - Vacuum command: 1 switches vacuum on, 0 off.
// - Height probe: 1 closes solenoid and retracts, 0 opens and extends.
// - Jet/melter temperature set, index 1 or 2, set point below 150.
// - Heater switch, index 1 jet, 2 melter: flag 1 on, 0 off.
// - Idle-off minutes stored; heaters switch off after that long idle.
// - Version query returns an identification string.
// - Drop count query returns drops since last counter clear.
// - Error query returns 0; without error, 1; after an error.
// - Stored error clears once the valve status reply is returned.
// - Valve status query returns 1; when closed, 0; when open.
// - Height switch query returns 1; when activated, else 0;.
// - Tactile switch query returns 1; when activated, else 0;.
// - Pressure query returns psi in decimal with one fractional digit.
// - Temperature query, index 1 jet, 2 melter, returns tenths format.

`define CTRL_OFS      8'h00
`define STATUS_OFS    8'h04
`define DROPS_OFS     8'h08
`define SETPT_OFS     8'h0c
`define CTRL_RST      1'b1
`define ST_VALVE      0
`define ST_JHEAT      1
`define ST_MHEAT      2
`define ST_VAC        3
`define ST_PROBE      4
`define ST_ERR        5
`define ST_BUSY       6
`define ST_RECIPE     8
`define ST_PSI        16

`define CH_SEMI       8'h3b
`define CH_COMMA      8'h2c
`define CH_SPACE      8'h20
`define CH_CR         8'h0d
`define CH_LF         8'h0a
`define CH_ZERO       8'h30
`define CH_NINE       8'h39
`define CH_A          8'h41
`define CH_Z          8'h5a
`define CH_DOT        8'h2e

`define RECIPE_PICK_CMD      16'h534d
`define DISPENSE_GO_CMD      16'h5347
`define VALVE_CMD            16'h5356
`define DROP_COUNT_CLEAR_CMD 16'h5344
`define FLUID_PSI_SET_CMD    16'h5355
`define VACUUM_CMD           16'h5341
`define HEIGHT_PROBE_CMD     16'h5353
`define TEMP_SET_CMD         16'h5348
`define HEATER_SWITCH_CMD    16'h534f
`define HEATER_IDLE_OFF_CMD  16'h4846
`define TRIGGER_DROP_COUNT_CMD 16'h4354
`define VERSION_QUERY        16'h4f56
`define DROP_COUNT_QUERY     16'h4f44
`define ERROR_QUERY          16'h4f45
`define VALVE_STATE_QUERY    16'h4f53
`define HEIGHT_SWITCH_QUERY  16'h4f48
`define TACTILE_SWITCH_QUERY 16'h4f4c
`define FLUID_PSI_QUERY      16'h4f55
`define TEMP_QUERY           16'h4f54

`define MAX_RECIPE    16'h0005
`define PSI_LIMIT     16'h004b
`define TEMP_LIMIT    16'h0096
`define ACC_MAX       16'h1998

`define CLK_NS        40
`define CLK_HZ        25000000
`define DROP_GAP_NS   5000000
`define DROP_GAP_CYC  ((`DROP_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define MINUTE_S      60
`define MINUTE_CYC    (`MINUTE_S * `CLK_HZ)
`endif

// >>> jdc_pkg.sv
/*
  Types for the jet dispense command parser: sensor and actuator bundles,
  parser and reply state encodings, the parsed command record.
  Assumes the constants of jdc_map.svh.
*/
package jdc_pkg;
  typedef struct packed {
    logic        heightSw;
    logic        tactileSw;
    logic [15:0] psiTenths;
    logic [15:0] jetTempTenths;
    logic [15:0] melterTempTenths;
  } sense_t;

  typedef struct packed {
    logic        valveOpen;
    logic        jetFire;
    logic        vacuumOn;
    logic        probeRetract;
    logic        jetHeaterOn;
    logic        melterHeaterOn;
    logic [2:0]  recipe;
    logic [15:0] psiSet;
    logic [15:0] jetTempSet;
    logic [15:0] melterTempSet;
  } act_t;

  typedef enum logic [2:0] {P_C0 = 3'b001, P_C1 = 3'b010, P_ARGS = 3'b100} parse_t;
  typedef enum logic [2:0] {R_IDLE = 3'b001, R_CONV = 3'b010, R_SEND = 3'b100} reply_t;

  typedef struct packed {
    logic [15:0] code;
    logic        bad;
    logic [1:0]  nVals;
  } cmd_t;
endpackage

// >>> jdc_checker.sv
/* Port checker for jet_dispense_command_parser.
   Bound into every instance of it; one clock, reset active high. */
`timescale 1ns/1ps
module jdc_checker (
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   prdata,
  input wire logic          pslverr,
  input wire logic          rxValid,
  input wire logic [7:0]    rxByte,
  input wire logic          txValid,
  input wire logic [7:0]    txByte,
  input wire logic          txReady,
  input wire jdc_pkg::act_t act
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic term;
  assign term = rxValid && rxByte == 8'h3b;
  a_act_after_term: assert property (
    $changed({act.valveOpen, act.vacuumOn, act.probeRetract, act.recipe, act.psiSet})
    |-> $past(term, 2)) else $error("setting moved without a command");
  a_heater_on_cmd: assert property (
    $rose(act.jetHeaterOn) || $rose(act.melterHeaterOn) |-> $past(term, 2))
    else $error("heater on without a command");
  a_recipe_range: assert property (act.recipe <= 3'd5)
    else $error("recipe out of range");
  a_psi_range: assert property (act.psiSet < 16'd75)
    else $error("pressure set out of range");
  a_temp_range: assert property (act.jetTempSet < 16'd150 && act.melterTempSet < 16'd150)
    else $error("temperature set out of range");
  a_fire_pulse: assert property (act.jetFire |=> (!act.jetFire) [*3])
    else $error("drop pulses too close");
  a_reply_holds: assert property (
    txValid && !txReady |=> txValid && $stable(txByte)) else $error("reply byte lost");
  a_bad_addr: assert property (
    psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}) |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
endmodule // jdc_checker

bind jet_dispense_command_parser jdc_checker chk_u (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .rxValid(rxValid),
  .rxByte(rxByte), .txValid(txValid), .txByte(txByte), .txReady(txReady), .act(act));

// >>> jdc_host.sv
/* Host model: sends ASCII commands byte by byte, takes replies.
   Assumes the block's clock; stalls at random when slow is high. */
`timescale 1ns/1ps
module jdc_host (
  input  wire logic       mclk,
  input  wire logic       slow,
  output logic            rxValid,
  output logic [7:0]      rxByte,
  output logic            txReady
);
  initial rxValid = 1'b0;
  initial rxByte = 8'h00;
  initial txReady = 1'b0;
  always @(posedge mclk) txReady <= slow ? 1'($urandom) : 1'b1;
  task send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge mclk);
      rxValid <= 1'b1;
      rxByte <= s[i];
    end
    @(posedge mclk);
    rxValid <= 1'b0;
    // Released line shows the inverse so a stale byte cannot pass
    rxByte <= ~rxByte;
  endtask
endmodule // jdc_host

// >>> testbench.sv
/* Bench for jet_dispense_command_parser: APB master, sensor values,
   reply watcher. Assumes jdc_host drives the command byte stream. */
`timescale 1ns/1ps
module testbench;
  logic            mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [7:0]      paddr = 8'h00, rxByte, txByte;
  logic [31:0]     pwdata = 32'h0, prdata, rd;
  logic            pready, pslverr, rxValid, txValid, txReady, er;
  jdc_pkg::sense_t sense = '0;
  jdc_pkg::act_t   act;
  int              n_errors = 0, comparisons = 0, fires = 0, v;
  string           expQ[$], got = "";
  string           bad[6] = '{"SV 1,1;", "XQ 3;", "SA 2;", "SU 75;", "SH 1 150;", "SM 6;"};
  always #20 mclk = ~mclk;
  jet_dispense_command_parser #(.DROP_GAP(4), .MINUTE(20)) dut_u (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxValid(rxValid), .rxByte(rxByte),
    .txValid(txValid), .txByte(txByte), .txReady(txReady), .sense(sense), .act(act));
  jdc_host host_u (.mclk(mclk), .slow(slow), .rxValid(rxValid), .rxByte(rxByte),
    .txReady(txReady));
  always @(posedge mclk) fires <= fires + int'(act.jetFire === 1'b1);
  task check(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask
  task check_reply(input string g);
    string e;
    e = expQ.size() > 0 ? expQ.pop_front() : "";
    comparisons++;
    if (g != e) begin
      n_errors++;
      $display("FAIL %0t reply %s want %s", $time, g, e);
    end
  endtask
  always @(posedge mclk) if (txValid === 1'b1 && txReady === 1'b1) begin
    got = {got, $sformatf("%c", txByte)};
    if (txByte === 8'h3b) begin
      check_reply(got);
      got = "";
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cmd(input string s);
    host_u.send(s);
    repeat (2) @(posedge mclk);
  endtask
  // Waits for the reply so a query never lands while one is still going out
  task query(input string s, input string e);
    expQ.push_back(e);
    cmd(s);
    for (int k = 0; k < 300 && expQ.size() > 0; k++) @(posedge mclk);
    check(expQ.size(), 0);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge mclk);
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    complete_run;
  end
  initial begin
    void'($urandom(32'h6ca3));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h1);
    cmd("SV 0,1;");
    check(act.valveOpen, 1);
    query("OS;", "0;");
    cmd("SV 0,0;");
    query("OS;", "1;");
    query("OV;", "JDC_0001;");
    $display("test valve done");
    v = $urandom % 1000;
    sense <= '{1'b1, 1'b0, 16'(v), 16'd1499, 16'd5};
    cmd("SU,40;");
    cmd("SH 1 140;");
    cmd("SH 2 110;");
    check(act.psiSet, 40);
    check({act.jetTempSet, act.melterTempSet}, {16'd140, 16'd110});
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, {16'd110, 16'd140});
    query("OU;", $sformatf("%0d.%0d;", v / 10, v % 10));
    query("OT 1;", "149.9;");
    query("OT 2;", "0.5;");
    slow <= 1'b1;
    query("OH;", "1;");
    query("OL;", "0;");
    $display("test readings done");
    for (int f = 1; f >= 0; f--) begin
      cmd($sformatf("SA %0d;", f));
      cmd($sformatf("SS %0d;", f));
      cmd($sformatf("SO 1,%0d;", f));
      cmd($sformatf("SO 2,%0d;", f));
      check({act.vacuumOn, act.probeRetract, act.jetHeaterOn, act.melterHeaterOn}, {4{f[0]}});
    end
    cmd("SO 1,1;");
    cmd("HF 1;");
    repeat (50) @(posedge mclk);
    check(act.jetHeaterOn, 0);
    cmd("CT 2,0,3;");
    cmd("SM 2;");
    check(act.recipe, 2);
    v = fires;
    cmd("SG;");
    repeat (20) @(posedge mclk);
    cmd("SG;");
    repeat (20) @(posedge mclk);
    check(fires - v, 6);
    query("OD;", "6;");
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 6);
    cmd("SD 0;");
    query("OD;", "0;");
    $display("test dispense done");
    foreach (bad[i]) begin
      cmd(bad[i]);
      query("OE;", "1;");
      query("OS;", "1;");
      query("OE;", "0;");
    end
    check({act.recipe, act.psiSet}, {3'd2, 16'd40});
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h00280200);
    apb(1'b0, 8'h10, 32'h0);
    check({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, 8'h00, 32'h0);
    cmd("SA 1;");
    check(act.vacuumOn, 0);
    apb(1'b1, 8'h00, 32'h1);
    $display("test errors done");
    complete_run;
  end
endmodule // testbench
